// ===== design/fts_top.sv
// Fault tally, self-test sequencing and core-rail shutdown, behind a Wishbone slave.
// Assumes fault and event inputs are synchronous one-cycle pulses or clean levels.
//
// How it works
// - Limit field 00,01,10,11 gives maximum 1,2,6,12; reset is 01.
// - Tally is four bits and starts at zero after reset.
// - Tally clears only on clear=1 with inverse=0 written together.
// - Refresh after refresh counter maxed lowers tally by one.
// - Each assigned fault raises the tally by one.
// - Channel faults count when enabled and routed to power good.
// - Error monitor faults count only in normal state when enabled.
// - Collector faults count when collector enable is set.
// - Analog test runs only if its enable bit is set.
// - Analog test checks CRC, oscillator, bandgaps and all monitors.
// - Analog test begun in setup checks power good and fail output read low.
// - One failure flag per check; all zero after success.
// - On-demand request allowed in normal or setup; self-clears at end.
// - On-demand test from setup drives fail output low.
// - On-demand test from normal keeps fail output high.
// - Logic test disabled only when disable code equals 0x36.
// - Controller boot, CRC or ECC error forces logic test anyway.
// - Logic test passed bit set on clean completion.
// - Core or internal rail over/undervoltage powers the device down.
// - Fault input pins are readable in real time.
// - Every watchdog failure raises the tally by one.
// - Tally at maximum with deep fail-safe enabled signals entry.
// - Limit and clear writable only in setup, locked after first refresh in setup with watchdog enabled.
`default_nettype none
module fts_top #(
  parameter int ANALOG_SELF_TEST_LEN = fts_pkg::ANALOG_SELF_TEST_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Device state and watchdog
  input wire fts_pkg::fts_state_e state_i,
  input wire logic wd_enabled_i,
  input wire logic wd_refresh_i,
  input wire logic wd_refresh_max_i,
  input wire logic wd_fail_i,
  // Fault sources
  input wire fts_pkg::fts_chan_s chan_i,
  input wire logic [1:0] error_monitor_input_i,
  input wire logic [1:0] error_input_tally_enable_i,
  input wire logic [1:0] fault_collector_input_i,
  input wire logic collector_tally_enable_i,
  input wire logic deep_failsafe_enable_i,
  // Self-test controls and results
  input wire logic analog_test_enable_i,
  input wire logic analog_self_test_start_i,
  input wire fts_pkg::fts_analog_self_test_s analog_self_test_check_i,
  input wire logic power_good_pin_i,
  input wire logic power_good_two_pin_i,
  input wire logic safety_fail_pin_i,
  input wire logic [7:0] logic_test_disable_code_i,
  input wire logic [2:0] otp_error_i,
  input wire logic logic_test_done_i,
  input wire logic logic_test_fail_i,
  // Rails and pins
  input wire logic [1:0] rail_ov_i,
  input wire logic [1:0] rail_uv_i,
  input wire logic [2:0] pin_realtime_status_i,
  // Outputs
  output logic deep_failsafe_o,
  output logic power_down_o,
  output logic safety_fail_low_o,
  output logic analog_self_test_busy_o,
  output logic logic_test_run_o
);
  // ==========================================================
  // Registers
  logic [1:0] limit;
  logic [3:0] tally;
  logic od_req;
  logic od_from_setup;
  logic locked;
  logic logic_test_passed;
  fts_pkg::fts_analog_self_test_s analog_self_test_flags;
  logic [15:0] analog_self_test_cnt;
  logic [3:0] tally_max;
  logic [3:0] next_tally;
  logic inc;
  logic dec;
  logic clr;
  logic wr;
  logic [fts_pkg::NUM_CH-1:0] ch_fault;

  typedef enum logic [1:0] {
    AB_IDLE,
    AB_RUN
  } fts_ab_e;
  fts_ab_e ab_state;

  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

  // ==========================================================
  // Limit decode
  always_comb begin
    unique case (limit)
      2'h0: tally_max = fts_pkg::MAX_SEL0;
      2'h1: tally_max = fts_pkg::MAX_SEL1;
      2'h2: tally_max = fts_pkg::MAX_SEL2;
      2'h3: tally_max = fts_pkg::MAX_SEL3;
    endcase
  end

  // ==========================================================
  // Fault sources
  for (genvar g = 0; g < fts_pkg::NUM_CH; g++) begin : g_ch
    assign ch_fault[g] = chan_i.tally_en[g] &&
      ((chan_i.ov[g] && chan_i.ov_routed[g]) || (chan_i.uv[g] && chan_i.uv_routed[g]));
  end

  assign inc = (|ch_fault) || wd_fail_i ||
    ((state_i == fts_pkg::ST_NORMAL) && |(error_monitor_input_i & error_input_tally_enable_i)) ||
    (collector_tally_enable_i && |fault_collector_input_i);
  assign dec = wd_refresh_i && wd_refresh_max_i;
  // Clear needs both bits of one write, complementary, while writable
  assign clr = wr && adr_i == fts_pkg::OFS_CTRL && !locked &&
    state_i == fts_pkg::ST_SETUP && dat_i[fts_pkg::CTRL_CLEAR_BIT] &&
    !dat_i[fts_pkg::CTRL_NCLEAR_BIT];

  always_comb begin
    next_tally = tally;
    if (inc && !dec && tally < tally_max) begin
      next_tally = tally + 4'h1;
    end else if (dec && !inc && tally != 4'h0) begin
      next_tally = tally - 4'h1;
    end
    if (next_tally > tally_max) begin
      next_tally = tally_max;
    end
    if (clr) begin
      next_tally = fts_pkg::TALLY_RESET;
    end
  end

  // ==========================================================
  // Tally
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tally <= fts_pkg::TALLY_RESET;
    end else begin
      tally <= next_tally;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deep_failsafe_o <= 1'b0;
    end else begin
      deep_failsafe_o <= deep_failsafe_enable_i && tally == tally_max;
    end
  end

  // ==========================================================
  // Limit and write lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked <= 1'b0;
    end else if (wd_enabled_i && wd_refresh_i && state_i == fts_pkg::ST_SETUP) begin
      locked <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit <= fts_pkg::LIMIT_RESET;
    end else if (wr && adr_i == fts_pkg::OFS_CTRL && !locked &&
                 state_i == fts_pkg::ST_SETUP &&
                 (dat_i[fts_pkg::CTRL_LIMIT_LSB +: 2] ==
                  ~dat_i[fts_pkg::CTRL_NLIMIT_LSB +: 2])) begin
      limit <= dat_i[fts_pkg::CTRL_LIMIT_LSB +: 2];
    end
  end

  // ==========================================================
  // Analog self-test sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ab_state <= AB_IDLE;
      analog_self_test_cnt <= 16'h0000;
      analog_self_test_flags <= '0;
      od_req <= 1'b0;
      od_from_setup <= 1'b0;
    end else begin
      unique case (ab_state)
        AB_IDLE: begin
          if (wr && adr_i == fts_pkg::OFS_CTRL && dat_i[fts_pkg::CTRL_ODREQ_BIT] &&
              (state_i == fts_pkg::ST_SETUP || state_i == fts_pkg::ST_NORMAL) &&
              analog_test_enable_i) begin
            od_req <= 1'b1;
            od_from_setup <= state_i == fts_pkg::ST_SETUP;
            ab_state <= AB_RUN;
            analog_self_test_cnt <= 16'h0000;
          end else if (analog_self_test_start_i && analog_test_enable_i) begin
            od_from_setup <= 1'b1;
            ab_state <= AB_RUN;
            analog_self_test_cnt <= 16'h0000;
          end
        end
        AB_RUN: begin
          analog_self_test_cnt <= analog_self_test_cnt + 16'h0001;
          if (analog_self_test_cnt == 16'(ANALOG_SELF_TEST_LEN - 1)) begin
            analog_self_test_flags <= analog_self_test_check_i;
            analog_self_test_flags.outs_high <= od_from_setup &&
              (power_good_pin_i || power_good_two_pin_i || safety_fail_pin_i);
            od_req <= 1'b0;
            ab_state <= AB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_self_test_busy_o <= 1'b0;
      safety_fail_low_o <= 1'b1;
    end else begin
      analog_self_test_busy_o <= ab_state == AB_RUN;
      // Low outside normal; held low for a test begun in setup
      safety_fail_low_o <= state_i != fts_pkg::ST_NORMAL ||
        (ab_state == AB_RUN && od_from_setup);
    end
  end

  // ==========================================================
  // Logic self-test and rail shutdown
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      logic_test_run_o <= 1'b0;
      logic_test_passed <= 1'b0;
      power_down_o <= 1'b0;
    end else begin
      logic_test_run_o <= logic_test_disable_code_i != fts_pkg::LOGIC_DISABLE_CODE ||
        |otp_error_i;
      if (logic_test_done_i && !logic_test_fail_i) begin
        logic_test_passed <= 1'b1;
      end
      if (|rail_ov_i || |rail_uv_i) begin
        power_down_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Bus read and acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= 32'h0000_0000;
      if (cyc_i && stb_i && !we_i && !ack_o) begin
        unique case (adr_i)
          fts_pkg::OFS_CTRL: dat_o <= {23'h0, od_req, 4'h0, ~limit, limit};
          fts_pkg::OFS_TALLY: dat_o <= {28'h0, tally};
          fts_pkg::OFS_ANALOG_SELF_TEST: dat_o <= {16'h0, $bits(fts_pkg::fts_analog_self_test_s)'(analog_self_test_flags)};
          fts_pkg::OFS_STATUS: dat_o <= {29'h0, locked, logic_test_run_o, logic_test_passed};
          fts_pkg::OFS_PINS: dat_o <= {29'h0, pin_realtime_status_i};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  a_tally_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    tally <= tally_max || $changed(limit)) else $error("tally above max");
  a_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    clr |=> tally == 4'h0) else $error("clear failed");
  a_inc_one: assert property (@(posedge clk_i) disable iff (rst_i)
    inc && !dec && !clr && tally < tally_max |=> tally == $past(tally) + 4'h1)
    else $error("no increment");
  a_dec_one: assert property (@(posedge clk_i) disable iff (rst_i)
    dec && !inc && !clr && tally != 4'h0 && tally <= tally_max |=> tally == $past(tally) - 4'h1)
    else $error("no decrement");
  a_deep_fs: assert property (@(posedge clk_i) disable iff (rst_i)
    deep_failsafe_enable_i && tally == tally_max |=> deep_failsafe_o)
    else $error("deep failsafe missing");
  a_od_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ab_state == AB_RUN ##1 ab_state == AB_IDLE |-> !od_req)
    else $error("request not cleared");
  a_fail_setup: assert property (@(posedge clk_i) disable iff (rst_i)
    ab_state == AB_RUN && od_from_setup |=> safety_fail_low_o)
    else $error("fail output not low");
  a_rail_down: assert property (@(posedge clk_i) disable iff (rst_i)
    |rail_uv_i |=> power_down_o [*2]) else $error("no power down");
  a_logic_self_test_code: assert property (@(posedge clk_i) disable iff (rst_i)
    logic_test_disable_code_i != fts_pkg::LOGIC_DISABLE_CODE |=> logic_test_run_o)
    else $error("logic test not run");
endmodule
`default_nettype wire

// ===== design/fts_pkg.sv
// Package for the fault tally and self-test block: offsets, fields, resets, types.
// Assumes a classic Wishbone slave with 32-bit data and a 100 MHz clock.
`default_nettype none
package fts_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TALLY = 8'h04;
  localparam logic [7:0] OFS_ANALOG_SELF_TEST = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_PINS = 8'h10;
  // ==========================================================
  // Control register fields
  localparam int CTRL_LIMIT_LSB = 0;
  localparam int CTRL_NLIMIT_LSB = 2;
  localparam int CTRL_CLEAR_BIT = 4;
  localparam int CTRL_NCLEAR_BIT = 5;
  localparam int CTRL_ODREQ_BIT = 8;
  // ==========================================================
  // Reset values and codes
  localparam logic [1:0] LIMIT_RESET = 2'h1;
  localparam logic [3:0] TALLY_RESET = 4'h0;
  localparam logic [7:0] LOGIC_DISABLE_CODE = 8'h36;
  localparam logic [3:0] MAX_SEL0 = 4'h1;
  localparam logic [3:0] MAX_SEL1 = 4'h2;
  localparam logic [3:0] MAX_SEL2 = 4'h6;
  localparam logic [3:0] MAX_SEL3 = 4'hC;
  // ==========================================================
  // Self-test timing
  localparam int ANALOG_SELF_TEST_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ANALOG_SELF_TEST_CYCLES = ANALOG_SELF_TEST_TIME_NS / CLK_PERIOD_NS;
  localparam int NUM_CH = 6;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_SETUP,
    ST_NORMAL,
    ST_OTHER
  } fts_state_e;
  typedef struct packed {
    logic crc_bad;
    logic osc_bad;
    logic bandgap_bad;
    logic [NUM_CH-1:0] ov_bad;
    logic [NUM_CH-1:0] uv_bad;
    logic outs_high;
  } fts_analog_self_test_s;
  typedef struct packed {
    logic [NUM_CH-1:0] ov;
    logic [NUM_CH-1:0] uv;
    logic [NUM_CH-1:0] ov_routed;
    logic [NUM_CH-1:0] uv_routed;
    logic [NUM_CH-1:0] tally_en;
  } fts_chan_s;
endpackage
`default_nettype wire

// ===== tb/fts_sw_model.sv
// Software model: a classic Wishbone master issuing register cycles.
// Assumes a slave that acks within 19 clock cycles.
`default_nettype none
module fts_sw_model (
  // Clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // Request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [3:0] sel_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o,
  output logic timeout_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cyc_o, stb_o, we_o, adr_o, dat_o, timeout_o} = '0;
    sel_o = 4'h0;
  end
  // ==========================================================
  // One bus cycle, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {1'b1, 1'b1, w, a, d};
    sel_o <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    q = dat_i;
    if (n >= 20) timeout_o <= 1'b1;
    {cyc_o, stb_o} <= 2'b00;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== tb/fault_counter_and_self_test_tb.sv
// Testbench for the fault tally and self-test block.
// Assumes fts_pkg, fts_top and the software model fts_sw_model.
`default_nettype none
module fault_counter_and_self_test_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, sw_to;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [1:0] rail_ov = '0;
  logic lt_fail = 1'b0;
  logic [31:0] wdat, rdat, q;
  fts_pkg::fts_state_e st = fts_pkg::ST_SETUP;
  logic wd_en = 1'b0, wd_rf = 1'b0, wd_mx = 1'b0, wd_fail = 1'b0;
  fts_pkg::fts_chan_s chan = '0;
  fts_pkg::fts_analog_self_test_s abk = '0;
  logic [1:0] emon = '0, em_en = 2'h3, fcol = '0, rail_uv = '0;
  logic fc_en = 1'b1, dfs_en = 1'b1, at_en = 1'b0, ab_go = 1'b0, pin_lo = 1'b0;
  logic [7:0] lcode = 8'h36;
  logic [2:0] otp_err = '0, pins = '0;
  logic lt_done = 1'b0;
  logic dfs_o, pd_o, sfl_o, busy_o, run_o;
  int failures = 0, samples_checked = 0, cycles = 0;
  typedef struct packed {logic [1:0] sel; logic [3:0] max;} fts_row_s;
  fts_row_s rows [4] = '{'{2'h0, 4'h1}, '{2'h1, 4'h2}, '{2'h2, 4'h6}, '{2'h3, 4'hC}};
  always #5 clk_i = ~clk_i;
  fts_sw_model fts_sw_model_i (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat), .timeout_o(sw_to));
  fts_top #(.ANALOG_SELF_TEST_LEN(4)) fts_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .state_i(st), .wd_enabled_i(wd_en), .wd_refresh_i(wd_rf),
    .wd_refresh_max_i(wd_mx), .wd_fail_i(wd_fail), .chan_i(chan),
    .error_monitor_input_i(emon), .error_input_tally_enable_i(em_en),
    .fault_collector_input_i(fcol), .collector_tally_enable_i(fc_en),
    .deep_failsafe_enable_i(dfs_en), .analog_test_enable_i(at_en), .analog_self_test_start_i(ab_go),
    .analog_self_test_check_i(abk), .power_good_pin_i(pin_lo), .power_good_two_pin_i(pin_lo),
    .safety_fail_pin_i(pin_lo), .logic_test_disable_code_i(lcode), .otp_error_i(otp_err),
    .logic_test_done_i(lt_done), .logic_test_fail_i(lt_fail), .rail_ov_i(rail_ov),
    .rail_uv_i(rail_uv), .pin_realtime_status_i(pins), .deep_failsafe_o(dfs_o),
    .power_down_o(pd_o), .safety_fail_low_o(sfl_o), .analog_self_test_busy_o(busy_o),
    .logic_test_run_o(run_o));
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    fts_sw_model_i.bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask
  task automatic ctl(input logic [31:0] d);
    fts_sw_model_i.bus(1'b1, fts_pkg::OFS_CTRL, d, q);
  endtask
  task automatic tl(input logic [3:0] e);
    rdc(fts_pkg::OFS_TALLY, 32'hF, {28'h0, e});
  endtask
  task automatic ev(input logic [5:0] o, u, input logic [1:0] e, f, input logic w, r);
    {chan.ov, chan.uv, emon, fcol, wd_fail, wd_rf} <= {o, u, e, f, w, r};
    @(posedge clk_i);
    {chan.ov, chan.uv, emon, fcol, wd_fail, wd_rf} <= '0;
    @(posedge clk_i);
  endtask
  task automatic waitb(input logic v);
    int n;
    n = 0;
    while (busy_o !== v && n < 30) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 30) failures++;
  endtask
  task automatic go;
    ab_go <= 1'b1;
    @(posedge clk_i);
    ab_go <= 1'b0;
  endtask
  task automatic end_of_test;
    if (sw_to === 1'b1) failures++;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test;
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    check(pd_o, 1'b0);
    rdc(fts_pkg::OFS_CTRL, 32'h3, {30'h0, fts_pkg::LIMIT_RESET});
    tl(4'h0);
    foreach (rows[i]) begin
      ctl({28'h0, ~rows[i].sel, rows[i].sel});
      ctl(32'h10);
      @(posedge clk_i);
      check(dfs_o, 1'b0);
      repeat (rows[i].max + 2) ev('0, '0, '0, '0, 1'b1, 1'b0);
      tl(rows[i].max);
      check(dfs_o, 1'b1);
    end
    ctl(32'h30);
    tl(4'hC);
    ctl(32'h00);
    tl(4'hC);
    ctl(32'h10);
    tl(4'h0);
    ev('0, '0, '0, '0, 1'b1, 1'b0);
    tl(4'h1);
    ev('0, '0, '0, '0, 1'b0, 1'b1);
    tl(4'h1);
    wd_mx <= 1'b1;
    ev('0, '0, '0, '0, 1'b0, 1'b1);
    tl(4'h0);
    ev('0, '0, '0, '0, 1'b0, 1'b1);
    tl(4'h0);
    wd_mx <= 1'b0;
    {chan.tally_en, chan.ov_routed, chan.uv_routed} <= {6'h21, 6'h3F, 6'h20};
    ev(6'h01, '0, '0, '0, 1'b0, 1'b0);
    ev('0, 6'h01, '0, '0, 1'b0, 1'b0);
    ev(6'h02, '0, '0, '0, 1'b0, 1'b0);
    tl(4'h1);
    ev('0, 6'h20, '0, '0, 1'b0, 1'b0);
    tl(4'h2);
    ev('0, '0, 2'h1, '0, 1'b0, 1'b0);
    tl(4'h2);
    st <= fts_pkg::ST_NORMAL;
    ev('0, '0, 2'h2, '0, 1'b0, 1'b0);
    tl(4'h3);
    ev('0, '0, '0, 2'h1, 1'b0, 1'b0);
    tl(4'h4);
    fc_en <= 1'b0;
    ev('0, '0, '0, 2'h2, 1'b0, 1'b0);
    tl(4'h4);
    st <= fts_pkg::ST_SETUP;
    go;
    repeat (3) @(posedge clk_i);
    check(busy_o, 1'b0);
    at_en <= 1'b1;
    abk <= 16'hA5C3;
    go;
    waitb(1'b1);
    waitb(1'b0);
    rdc(fts_pkg::OFS_ANALOG_SELF_TEST, 32'hFFFF, 32'hA5C2);
    abk <= '0;
    go;
    waitb(1'b1);
    waitb(1'b0);
    rdc(fts_pkg::OFS_ANALOG_SELF_TEST, 32'hFFFF, 32'h0);
    pin_lo <= 1'b1;
    go;
    waitb(1'b1);
    waitb(1'b0);
    rdc(fts_pkg::OFS_ANALOG_SELF_TEST, 32'hFFFF, 32'h1);
    pin_lo <= 1'b0;
    ctl(32'h100);
    waitb(1'b1);
    check(sfl_o, 1'b1);
    waitb(1'b0);
    rdc(fts_pkg::OFS_CTRL, 32'h100, 32'h0);
    st <= fts_pkg::ST_NORMAL;
    @(posedge clk_i);
    ctl(32'h100);
    repeat (3) begin
      @(posedge clk_i);
      check(sfl_o, 1'b0);
    end
    waitb(1'b0);
    st <= fts_pkg::ST_SETUP;
    check(run_o, 1'b0);
    lcode <= 8'h37;
    repeat (3) @(posedge clk_i);
    check(run_o, 1'b1);
    lcode <= 8'h36;
    for (int b = 0; b < 3; b++) begin
      otp_err <= 3'h1 << b;
      repeat (3) @(posedge clk_i);
      check(run_o, 1'b1);
    end
    lt_fail <= 1'b1;
    lt_done <= 1'b1;
    @(posedge clk_i);
    lt_done <= 1'b0;
    lt_fail <= 1'b0;
    rdc(fts_pkg::OFS_STATUS, 32'h1, 32'h0);
    lt_done <= 1'b1;
    @(posedge clk_i);
    lt_done <= 1'b0;
    rdc(fts_pkg::OFS_STATUS, 32'h1, 32'h1);
    pins <= 3'h5;
    @(posedge clk_i);
    rdc(fts_pkg::OFS_PINS, 32'h7, 32'h5);
    wd_en <= 1'b1;
    ev('0, '0, '0, '0, 1'b0, 1'b1);
    ctl(32'h0C);
    rdc(fts_pkg::OFS_CTRL, 32'h3, 32'h3);
    rdc(fts_pkg::OFS_STATUS, 32'h4, 32'h4);
    rdc(8'h14, 32'hFFFFFFFF, 32'h0);
    rail_uv <= 2'h2;
    repeat (3) @(posedge clk_i);
    rail_uv <= 2'h0;
    repeat (3) @(posedge clk_i);
    check(pd_o, 1'b1);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(pd_o, 1'b0);
    tl(4'h0);
    rail_ov <= 2'h1;
    repeat (3) @(posedge clk_i);
    check(pd_o, 1'b1);
    rail_ov <= 2'h0;
    end_of_test;
  end
endmodule
`default_nettype wire
